// *** bench/adc_cfg_props.sv ***
// property checker for the measurement setup block
`timescale 1ns/100ps
`default_nettype none
module adc_cfg_props (
    input wire logic                 core_clk,     // clock
    input wire logic                 rst,          // sync reset
    input wire adc_pkg::reg_req_type req,          // request
    input wire logic [15:0]          rdata,        // read data
    input wire logic                 convActive,   // converting
    input wire logic                 resultValid,  // result pulse
    input wire logic signed [15:0]   shuntResult,  // shunt result
    input wire logic signed [31:0]   currentResult // current result
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    logic        swr;
    logic        wr1;
    logic [15:0] setup;
    logic [14:0] scale;
    assign swr = req.write && req.addr == 6'h00 && req.wdata[15];
    assign wr1 = req.write && req.addr == 6'h01;
    // shadows follow host writes so readback and products can be predicted
    always_ff @(posedge core_clk)
    begin
        if (rst || swr)
        begin
            setup <= 16'hFB68;
            scale <= 15'h1000;
        end
        else
        begin
            if (wr1) setup <= req.wdata;
            if (req.write && req.addr == 6'h02) scale <= req.wdata[14:0];
        end
    end
    rst_setup_a: assert property ($past(rst) && req.read && req.addr == 6'h01 |=> rdata == 16'hFB68)
        else $error("setup default wrong");
    setup_read_a: assert property (req.read && !req.write && req.addr == 6'h01 |=> rdata == setup)
        else $error("setup readback wrong");
    scale_read_a: assert property (req.read && !req.write && req.addr == 6'h02 |=> rdata == {1'b0, scale})
        else $error("scaling readback wrong");
    swr_clear_a: assert property (req.read && req.addr == 6'h00 |=> rdata == 16'h0000)
        else $error("reset bit did not clear");
    shut_idle_a: assert property (wr1 && req.wdata[14:12] == 3'h0 |=> !convActive [*8])
        else $error("conversion in shutdown");
    trig_start_a: assert property (wr1 && !req.wdata[15] && req.wdata[14:12] != 3'h0 |-> ##[1:8] convActive)
        else $error("triggered pass did not start");
    trig_stop_a: assert property ((!setup[15] && setup[14:12] != 3'h0 && !convActive && !req.write) [*8]
        |=> !convActive)
        else $error("conversion after triggered pass");
    result_hold_a: assert property (!$stable(shuntResult) && !$past(req.write) |-> resultValid)
        else $error("result changed without pulse");
    current_calc_a: assert property (resultValid && !req.write ##1 !req.write
        |=> currentResult == shuntResult * $signed({1'b0, scale}))
        else $error("current product wrong");
    cover property (resultValid);
    cover property (swr);
    cover property (wr1 && req.wdata[15:12] == 4'h9);
endmodule : adc_cfg_props
bind adc_measurement_config adc_cfg_props adc_cfg_props_i (.core_clk, .rst, .req, .rdata, .convActive,
    .resultValid, .shuntResult, .currentResult);
`default_nettype wire

// *** bench/host_model.sv ***
// host side model issuing register accesses
`timescale 1ns/100ps
`default_nettype none
module host_model (
    input  wire logic                core_clk, // clock
    output var adc_pkg::reg_req_type req       // request
);
    initial req = '0;
    // idle cycle after each access keeps every change one per time step
    task automatic access(input logic [1:0] wr, input logic [5:0] a, input logic [15:0] d);
        req = '{wr[1], wr[0], a, d};
        @(posedge core_clk);
        #1;
        req = '0;
        @(posedge core_clk);
        #1;
    endtask : access
endmodule : host_model
`default_nettype wire

// *** bench/tb_top.sv ***
// self-checking bench for the measurement setup block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic                 core_clk;
    logic                 rst;
    adc_pkg::reg_req_type req;
    logic [15:0]          rdata, busSample, busResult, lf;
    logic signed [15:0]   shuntSample, tempSample, shuntResult, tempResult;
    logic                 convActive, resultValid;
    logic [1:0]           activeChan;
    logic signed [31:0]   currentResult;
    logic [15:0]          mdl [3];
    int                   errors, n_checks, c, t;
    adc_measurement_config adc_measurement_config_i (.core_clk, .rst, .req, .rdata, .shuntSample, .busSample,
        .tempSample, .convActive, .activeChan, .resultValid, .shuntResult, .busResult, .tempResult, .currentResult);
    host_model host_model_i (.core_clk, .req);
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
        n_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask : check
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        host_model_i.access(2'b10, a, d);
        if (a == 6'h00 && d[15]) mdl = '{16'h0000, 16'hFB68, 16'h1000};
        else if (a < 6'h03) mdl[a[1:0]] = (a == 6'h02) ? d & 16'h7FFF : (a == 6'h01) ? d : 16'h0000;
    endtask : wr
    task automatic rd(input logic [5:0] a);
        host_model_i.access(2'b01, a, 16'h0000);
        check(rdata, (a < 6'h03) ? mdl[a[1:0]] : 16'h0000, "read data");
    endtask : rd
    task automatic wait_valid();
        c = 0;
        do
        begin
            @(posedge core_clk);
            #1;
            c++;
        end while (resultValid !== 1'b1 && c < 30000);
        check(resultValid, 32'd1, "result timed out");
    endtask : wait_valid
    task automatic idle(input int n);
        t = 0;
        repeat (n)
        begin
            @(posedge core_clk);
            #1;
            t += int'(convActive !== 1'b0);
        end
    endtask : idle
    task automatic complete_run();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : complete_run
    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    initial
    begin
        #(60000 * 20);
        errors++;
        complete_run();
    end
    initial
    begin
        rst = 1'b1;
        lf = 16'hD920;
        busSample = 16'h0000;
        shuntSample = 16'sh0000;
        tempSample = 16'sh0000;
        mdl = '{16'h0000, 16'hFB68, 16'h1000};
        repeat (10) @(posedge core_clk);
        #1;
        rst = 1'b0;
        rd(6'h01);
        rd(6'h02);
        rd(6'h03);
        wr(6'h02, 16'hFFFF);
        rd(6'h02);
        wr(6'h00, 16'h8000);
        rd(6'h01);
        rd(6'h02);
        rd(6'h00);
        for (int k = 0; k < 2; k++)
        begin
            lf = lfsr(lf);
            wr(6'h01, {k[0], 3'h0, lf[11:0]});
            rd(6'h01);
            idle(50);
            check(t, 0, "converting in shutdown");
        end
        $display("registers and shutdown done");
        lf = lfsr(lf);
        shuntSample = lf;
        busSample = ~lf;
        wr(6'h02, lf);
        wr(6'h01, 16'h3000);
        wait_valid();
        idle(3000);
        check(busResult, busSample, "bus result");
        check(shuntResult, shuntSample, "shunt result");
        check(currentResult, int'(shuntSample) * int'(lf[14:0]), "current");
        idle(200);
        check(t, 0, "triggered pass repeated");
        for (int k = 0; k < 2; k++)
        begin
            wr(6'h01, {4'h1, k[2:0], 9'h000});
            wait_valid();
            check(c >= (k ? 4200 : 2500) && c <= (k ? 4220 : 2520), 1, "conversion time");
            idle(10);
        end
        wr(6'h01, 16'h1001);
        wait_valid();
        check(c >= 10000 && c <= 10080, 1, "averaging span");
        check(busResult, busSample, "averaged bus");
        lf = lfsr(lf);
        tempSample = lf;
        wr(6'h01, 16'h4000);
        idle(10);
        check(activeChan, 32'd2, "temperature channel");
        wait_valid();
        check(tempResult, tempSample, "temperature result");
        idle(20);
        check(activeChan, 32'd0, "pass wrapped to bus");
        check(t, 0, "temperature pass repeated");
        wr(6'h01, 16'h9000);
        wait_valid();
        wait_valid();
        check(c >= 2500 && c <= 2520, 1, "continuous repeat");
        wr(6'h01, 16'h0000);
        $display("conversion tests done");
        complete_run();
    end
endmodule : tb_top
`default_nettype wire

// *** common/adc_cfg.svh ***
// register offsets, field positions, reset values and timing figures of the measurement setup block
`ifndef ADC_CFG_SVH
`define ADC_CFG_SVH
`define SETUP_ADDR        6'h01
`define SCALE_ADDR        6'h02
`define MAIN_CFG_ADDR     6'h00
`define SWRST_BIT         15
`define MODE_MSB          15
`define MODE_LSB          12
`define BUSCT_MSB         11
`define BUSCT_LSB         9
`define SHCT_MSB          8
`define SHCT_LSB          6
`define TCT_MSB           5
`define TCT_LSB           3
`define MEAN_MSB          2
`define MEAN_LSB          0
`define SETUP_RESET       16'hFB68
`define SCALE_RESET       15'h1000
`define CLK_MHZ           50
`define CT0_US            50
`define CT1_US            84
`define CT2_US            150
`define CT3_US            280
`define CT4_US            540
`define CT5_US            1052
`define CT6_US            2074
`define CT7_US            4120
`endif

// *** common/adc_pkg.sv ***
// types shared by the measurement setup block
package adc_pkg;
    typedef struct packed {
        logic [3:0] mode;
        logic [2:0] busTime;
        logic [2:0] shuntTime;
        logic [2:0] tempTime;
        logic [2:0] meanCount;
    } setup_type;

    typedef struct packed {
        logic        write;
        logic        read;
        logic [5:0]  addr;
        logic [15:0] wdata;
    } reg_req_type;

    typedef enum logic [1:0] {
        CH_BUS,
        CH_SHUNT,
        CH_TEMP
    } channel_type;
endpackage : adc_pkg

// *** hdl/adc_measurement_config.sv ***
// measurement setup and shunt scaling registers with the conversion scheduler
// How it works
// - mode field bits 15:12, resets to Fh
// - codes 0 and 8 mean shutdown
// - codes 1-7 run one triggered pass
// - codes 9-15 repeat passes continuously
// - bus time field bits 11:9, reset 5
// - shunt time field bits 8:6, reset 5
// - temperature time field bits 5:3, reset 5
// - time codes map 50 to 4120 us
// - mean count bits 2:0, reset 0, all channels
// - mean codes select 1 to 1024 samples
// - results update only after full averaging
// - scaling bit 15 reads zero
// - 15-bit scaling constant, reset 1000h, scales current
// - scaling constant sets current resolution
// - software reset restores defaults, self-clears
`timescale 1ns/100ps
`default_nettype none
`include "adc_cfg.svh"
module adc_measurement_config (
    input  wire logic                core_clk,     // core clock
    input  wire logic                rst,          // sync reset, active high
    input  wire adc_pkg::reg_req_type req,         // register access from serial engine
    output logic [15:0]              rdata,        // read data, registered
    input  wire logic signed [15:0]  shuntSample,  // raw shunt sample from modulator
    input  wire logic        [15:0]  busSample,    // raw bus sample
    input  wire logic signed [15:0]  tempSample,   // raw temperature sample
    output logic                     convActive,   // a channel is converting
    output logic [1:0]               activeChan,   // channel being converted
    output logic                     resultValid,  // one-cycle pulse, result updated
    output logic signed [15:0]       shuntResult,  // averaged shunt voltage
    output logic        [15:0]       busResult,    // averaged bus voltage
    output logic signed [15:0]       tempResult,   // averaged temperature
    output logic signed [31:0]       currentResult // shunt result times scaling constant
);
    adc_pkg::setup_type setup;
    logic [14:0]        scale;
    logic               softReset;
    logic               passPending;
    logic               timerStart;
    logic               timerBusy;
    logic               timerDone;
    logic [2:0]         chanTime;
    logic [10:0]        sampleCount;
    logic signed [26:0] accum;
    adc_pkg::channel_type chan;

    function automatic logic [10:0] mean_samples(input logic [2:0] code);
        case (code)
            3'h0: mean_samples = 11'd1;
            3'h1: mean_samples = 11'd4;
            3'h2: mean_samples = 11'd16;
            3'h3: mean_samples = 11'd64;
            3'h4: mean_samples = 11'd128;
            3'h5: mean_samples = 11'd256;
            3'h6: mean_samples = 11'd512;
            default: mean_samples = 11'd1024;
        endcase
    endfunction : mean_samples

    function automatic logic [3:0] mean_shift(input logic [2:0] code);
        case (code)
            3'h0: mean_shift = 4'd0;
            3'h1: mean_shift = 4'd2;
            3'h2: mean_shift = 4'd4;
            3'h3: mean_shift = 4'd6;
            3'h4: mean_shift = 4'd7;
            3'h5: mean_shift = 4'd8;
            3'h6: mean_shift = 4'd9;
            default: mean_shift = 4'd10;
        endcase
    endfunction : mean_shift

    // channel enable mask: bit0 bus, bit1 shunt, bit2 temperature
    function automatic logic chan_on(input logic [3:0] mode, input adc_pkg::channel_type c);
        case (c)
            adc_pkg::CH_BUS:   chan_on = mode[0];
            adc_pkg::CH_SHUNT: chan_on = mode[1];
            default:           chan_on = mode[2];
        endcase
    endfunction : chan_on

    wire logic shutdown   = (setup.mode[2:0] == 3'h0);
    wire logic continuous = setup.mode[3];
    wire logic wrSetup    = req.write && (req.addr == `SETUP_ADDR);
    wire logic skipChan   = passPending && !shutdown && !timerBusy && !timerDone && !chan_on(setup.mode, chan);
    // a pass ends on the temperature slot, by its result or by skipping it, so a bus-only pass also ends
    wire logic passEnd    = (chan == adc_pkg::CH_TEMP) && ((timerDone && sampleCount == 11'd1) || skipChan);

    assign softReset = req.write && (req.addr == `MAIN_CFG_ADDR) && req.wdata[`SWRST_BIT];

    always_ff @(posedge core_clk)
    begin
        if (rst || softReset)
        begin
            setup <= adc_pkg::setup_type'(`SETUP_RESET);
            scale <= `SCALE_RESET;
        end
        else if (wrSetup)
        begin
            setup.mode      <= req.wdata[`MODE_MSB:`MODE_LSB];
            setup.busTime   <= req.wdata[`BUSCT_MSB:`BUSCT_LSB];
            setup.shuntTime <= req.wdata[`SHCT_MSB:`SHCT_LSB];
            setup.tempTime  <= req.wdata[`TCT_MSB:`TCT_LSB];
            setup.meanCount <= req.wdata[`MEAN_MSB:`MEAN_LSB];
        end
        else if (req.write && req.addr == `SCALE_ADDR)
            scale <= req.wdata[14:0];
    end

    // read data; the software reset bit always reads back zero since it self-clears
    always_ff @(posedge core_clk)
    begin
        if (rst)
            rdata <= 16'h0000;
        else if (req.read)
        begin
            if (req.addr == `SETUP_ADDR)
                rdata <= setup;
            else if (req.addr == `SCALE_ADDR)
                rdata <= {1'b0, scale};
            else
                rdata <= 16'h0000;
        end
    end

    // a pass is armed by any setup write with a live code; continuous modes re-arm at pass end
    always_ff @(posedge core_clk)
    begin
        if (rst || softReset)
            passPending <= 1'b1;
        else if (wrSetup)
            passPending <= (req.wdata[14:12] != 3'h0);
        else if (passEnd)
            passPending <= continuous;
    end

    always_comb
    begin
        case (chan)
            adc_pkg::CH_BUS:   chanTime = setup.busTime;
            adc_pkg::CH_SHUNT: chanTime = setup.shuntTime;
            default:           chanTime = setup.tempTime;
        endcase
    end

    // skipped channels take no time; the walk bus, shunt, temp runs one channel per cycle when off
    assign timerStart = passPending && !shutdown && !timerBusy && !timerDone && chan_on(setup.mode, chan);

    always_ff @(posedge core_clk)
    begin
        if (rst || softReset || wrSetup)
        begin
            chan        <= adc_pkg::CH_BUS;
            sampleCount <= 11'd0;
            accum       <= '0;
            resultValid <= 1'b0;
        end
        else
        begin
            resultValid <= 1'b0;
            if (timerStart && sampleCount == 11'd0)
            begin
                sampleCount <= mean_samples(setup.meanCount);
                accum       <= '0;
            end
            else if (skipChan)
                chan <= (chan == adc_pkg::CH_TEMP) ? adc_pkg::CH_BUS : adc_pkg::channel_type'(chan + 2'd1);
            if (timerDone)
            begin
                case (chan)
                    adc_pkg::CH_BUS:   accum <= accum + 27'(busSample);
                    adc_pkg::CH_SHUNT: accum <= accum + 27'(shuntSample);
                    default:           accum <= accum + 27'(tempSample);
                endcase
                sampleCount <= sampleCount - 11'd1;
                if (sampleCount == 11'd1)
                begin
                    resultValid <= 1'b1;
                    chan <= (chan == adc_pkg::CH_TEMP) ? adc_pkg::CH_BUS : adc_pkg::channel_type'(chan + 2'd1);
                end
            end
        end
    end

    // results move only when the last sample of the averaging run lands
    always_ff @(posedge core_clk)
    begin
        if (rst || softReset)
        begin
            shuntResult   <= 16'sh0000;
            busResult     <= 16'h0000;
            tempResult    <= 16'sh0000;
            currentResult <= 32'sh00000000;
        end
        else if (timerDone && sampleCount == 11'd1)
        begin
            case (chan)
                adc_pkg::CH_BUS:
                    busResult <= 16'((accum + 27'(busSample)) >>> mean_shift(setup.meanCount));
                adc_pkg::CH_SHUNT:
                begin
                    shuntResult   <= 16'((accum + 27'(shuntSample)) >>> mean_shift(setup.meanCount));
                    // scaling constant gives the current lsb weight
                    currentResult <= 32'(16'((accum + 27'(shuntSample)) >>> mean_shift(setup.meanCount))
                                     * $signed({1'b0, scale}));
                end
                default:
                    tempResult <= 16'((accum + 27'(tempSample)) >>> mean_shift(setup.meanCount));
            endcase
        end
    end

    assign convActive = timerBusy;
    assign activeChan = chan;

    conv_timer u_timer (
        .core_clk (core_clk),
        .rst      (rst || softReset || wrSetup),
        .start    (timerStart),
        .timeCode (chanTime),
        .busy     (timerBusy),
        .done     (timerDone)
    );
endmodule : adc_measurement_config
`default_nettype wire

// *** hdl/conv_timer.sv ***
// one-channel conversion timer: counts the selected duration then pulses done
`timescale 1ns/100ps
`default_nettype none
`include "adc_cfg.svh"
module conv_timer #(
    parameter int CLK_MHZ = `CLK_MHZ
) (
    input  wire logic       core_clk,  // core clock
    input  wire logic       rst,       // sync reset
    input  wire logic       start,     // begin one conversion
    input  wire logic [2:0] timeCode,  // duration select
    output logic            busy,      // converting
    output logic            done       // one-cycle pulse at end
);
    localparam int CW = 18;
    logic [CW-1:0] count;

    function automatic logic [CW-1:0] cycles(input logic [2:0] code);
        int us;
        case (code)
            3'h0: us = `CT0_US;
            3'h1: us = `CT1_US;
            3'h2: us = `CT2_US;
            3'h3: us = `CT3_US;
            3'h4: us = `CT4_US;
            3'h5: us = `CT5_US;
            3'h6: us = `CT6_US;
            default: us = `CT7_US;
        endcase
        cycles = CW'(us * CLK_MHZ);
    endfunction : cycles

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            count <= '0;
            busy  <= 1'b0;
            done  <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            if (start && !busy)
            begin
                count <= cycles(timeCode) - CW'(1);
                busy  <= 1'b1;
            end
            else if (busy)
            begin
                if (count == '0)
                begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
                else
                    count <= count - CW'(1);
            end
        end
    end
endmodule : conv_timer
`default_nettype wire
